// ### verilog/spi_rb_pkg.sv
// constants, field layouts and the frame check shared by both ends of the readback link
// assumes a 100 MHz system clock on both ends and an 80 ns serial clock
package spi_rb_pkg;

    localparam int CLK_PERIOD_NS = 10;
    localparam int SCLK_PERIOD_NS = 80;
    localparam int SCLK_HALF_CYC = SCLK_PERIOD_NS / (2 * CLK_PERIOD_NS);

    localparam int FRAME_BITS = 32;
    localparam int ITEM_BITS = 24;
    localparam logic [5:0] FRAME_EDGES = 6'd32;
    localparam logic [4:0] ITEM_LAST = 5'd23;
    localparam logic [7:0] CRC_POLY = 8'h07;
    localparam logic [7:0] CRC_INIT = 8'h00;

    // device register map limits
    localparam logic [6:0] READ_SELECT_ADDR = 7'h41;
    localparam logic [6:0] REG_TOP_ADDR = 7'h46;
    localparam logic [6:0] GAP0_LO = 7'h30;
    localparam logic [6:0] GAP0_HI = 7'h3b;
    localparam logic [6:0] GAP1_LO = 7'h3d;
    localparam logic [6:0] GAP1_HI = 7'h40;

    // readback select register layout
    localparam int RS_ADDR_LSB = 0;
    localparam int RS_INFO_BIT = 7;
    localparam int RS_AUTO_BIT = 8;
    localparam logic [15:0] READ_SELECT_RST = 16'h0000;

    // controller register map, byte offsets on the wishbone bus
    localparam logic [7:0] HOST_TXD = 8'h00;
    localparam logic [7:0] HOST_CTRL = 8'h04;
    localparam logic [7:0] HOST_RXD = 8'h08;
    localparam logic [7:0] HOST_IRQ_STS = 8'h0c;
    localparam logic [7:0] HOST_IRQ_CLR = 8'h10;
    localparam logic [7:0] HOST_IRQ_EN = 8'h14;
    localparam logic [7:0] HOST_STATE = 8'h18;
    localparam int CTRL_HOLD_BIT = 0;
    localparam int IRQ_W = 3;
    localparam int IRQ_DONE = 0;
    localparam int IRQ_CRC = 1;
    localparam int IRQ_STUCK = 2;

    function automatic logic [7:0] crc8(input logic [23:0] d);
        logic [7:0] c;
        c = CRC_INIT;
        for (int i = 23; i >= 0; i--) begin
            c = (c[7] ^ d[i]) ? ({c[6:0], 1'b0} ^ CRC_POLY) : {c[6:0], 1'b0};
        end
        return c;
    endfunction : crc8

endpackage : spi_rb_pkg

// ### verilog/spi_rb_if.sv
// the four wires of the serial readback link
// assumes the controller end drives clock, frame select and inbound data
interface spi_rb_if;
    logic sclk;
    logic sync_n;
    logic sdi;
    logic sdo;

    modport dev (
        input sclk,
        input sync_n,
        input sdi,
        output sdo
    );

    modport host (
        output sclk,
        output sync_n,
        output sdi,
        input sdo
    );
endinterface : spi_rb_if

// ### verilog/spi_rb_device.sv
// device end of the serial link: write framing check, two-stage and automatic readback, streaming
// assumes register contents come from same-clock logic, answered combinationally for o_rd_addr
// Overview of operation
// - info 0: word 1, address, data, crc
// - info 1: 1, 0, alert, ready, comparators
// - streaming keeps shifting while clocks come
// - master keeps frame select low to stream
// - streaming steps to next register each word; the code holds at REG_TOP_ADDR (0x46) and repeats it
// - edges must be 32 plus 24n, else error; the code also flags any edges past 32 in a frame that is not a read
// - streamed item is 16 data, 8 crc
// - no register writes while streaming
// - software sets auto-readback enable bit
// - auto readback returns pointed register every transfer
// - without auto readback use two-frame read
// - frame end reloads selected readback address
// - select held low after auto read streams
// - bit 31 on select fall, rest rising
// - read: select address, then any frame
// - crc x^8+x^2+x+1 over 24 bits
//
// Local design decisions: the Wishbone interface to the registers and the placing of the registers.
module spi_rb_device
    import spi_rb_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rstn,
    spi_rb_if.dev link,
    output logic [6:0] o_rd_addr,
    input wire logic [15:0] i_rd_data,
    input wire logic i_alert,
    input wire logic i_adc_rdy,
    input wire logic [3:0] i_din_comp,
    output logic o_wr_stb,
    output logic [6:0] o_wr_addr,
    output logic [15:0] o_wr_data,
    output logic [15:0] o_read_select,
    output logic o_streaming,
    output logic o_clock_count_error,
    output logic o_crc_error
);

    logic [2:0] sclk_q;
    logic [2:0] sync_q;
    logic [1:0] sdi_q;
    logic sclk_rise;
    logic sclk_fall;
    logic sync_fall;
    logic sync_rise;
    logic in_frame;

    logic [31:0] rx_r;
    logic [5:0] fcnt_r;
    logic [5:0] rcnt_r;
    logic [4:0] icnt_r;
    logic extra_r;
    logic active_r;
    logic rb_pend_r;
    logic [31:0] word_r;
    logic [4:0] idx_r;
    logic sdo_r;
    logic [6:0] addr_r;
    logic [15:0] rdsel_r;

    logic [7:0] hdr;
    logic [15:0] data;
    logic [31:0] tx_word;
    logic len_ok;
    logic crc_ok;
    logic accept;
    logic sel_write;

    // sclk, frame select and sdi share the same two-stage delay so they stay aligned
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            sclk_q <= 3'h7;
            sync_q <= 3'h7;
            sdi_q <= 2'h0;
        end else begin
            sclk_q <= {sclk_q[1:0], link.sclk};
            sync_q <= {sync_q[1:0], link.sync_n};
            sdi_q <= {sdi_q[0], link.sdi};
        end
    end

    assign in_frame = ~sync_q[1];
    assign sclk_rise = in_frame & sclk_q[1] & ~sclk_q[2];
    assign sclk_fall = in_frame & ~sclk_q[1] & sclk_q[2];
    assign sync_fall = ~sync_q[1] & sync_q[2];
    assign sync_rise = sync_q[1] & ~sync_q[2];

    function automatic logic mapped(input logic [6:0] a);
        return (a <= REG_TOP_ADDR) && !(a >= GAP0_LO && a <= GAP0_HI) && !(a >= GAP1_LO && a <= GAP1_HI);
    endfunction : mapped

    // outbound word for the current read address
    always_comb begin
        data = mapped(addr_r) ? i_rd_data : 16'h0000;
        if (rdsel_r[RS_INFO_BIT]) begin
            hdr = {1'b1, 1'b0, i_alert, i_adc_rdy, i_din_comp};
        end else begin
            hdr = {1'b1, addr_r};
        end
        tx_word = {hdr, data, crc8({hdr, data})};
    end

    // inbound shift on falling edges, frame checks
    assign crc_ok = (rx_r[7:0] == crc8(rx_r[31:8]));
    assign len_ok = (rcnt_r == FRAME_EDGES) && (icnt_r == 5'd0) && (!extra_r || active_r);
    assign accept = len_ok && !extra_r && (fcnt_r == FRAME_EDGES) && crc_ok;
    assign sel_write = accept && (rx_r[30:24] == READ_SELECT_ADDR);

    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            rx_r <= 32'h0000_0000;
            fcnt_r <= 6'h00;
        end else if (sync_fall) begin
            fcnt_r <= 6'h00;
        end else if (sclk_fall) begin
            if (fcnt_r <= FRAME_EDGES) begin
                fcnt_r <= fcnt_r + 6'h01;
            end
            if (fcnt_r < FRAME_EDGES) begin
                rx_r <= {rx_r[30:0], sdi_q[1]};
            end
        end
    end

    // rising edge counting: first 32, then items of 24
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            rcnt_r <= 6'h00;
            icnt_r <= 5'h00;
            extra_r <= 1'b0;
        end else if (sync_fall) begin
            rcnt_r <= 6'h00;
            icnt_r <= 5'h00;
            extra_r <= 1'b0;
        end else if (sclk_rise) begin
            if (rcnt_r < FRAME_EDGES) begin
                rcnt_r <= rcnt_r + 6'h01;
            end else begin
                extra_r <= 1'b1;
                icnt_r <= (icnt_r == ITEM_LAST) ? 5'h00 : icnt_r + 5'h01;
            end
        end
    end

    // a frame is a read when it follows a select write or auto readback is on
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            active_r <= 1'b0;
            o_streaming <= 1'b0;
        end else if (sync_fall) begin
            active_r <= rb_pend_r | rdsel_r[RS_AUTO_BIT];
            o_streaming <= 1'b0;
        end else if (sync_rise) begin
            o_streaming <= 1'b0;
        end else if (sclk_rise && rcnt_r == FRAME_EDGES) begin
            o_streaming <= active_r;
        end
    end

    // outbound shifter: msb straight off the select fall, the rest on rising edges
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            word_r <= 32'h0000_0000;
            idx_r <= 5'h00;
            sdo_r <= 1'b0;
        end else if (sync_fall) begin
            word_r <= tx_word;
            idx_r <= 5'd31;
            sdo_r <= 1'b1;
        end else if (sclk_rise) begin
            if (idx_r == 5'h00) begin
                // next item: address field is not resent, only data and crc
                word_r <= tx_word;
                idx_r <= ITEM_LAST;
                sdo_r <= tx_word[ITEM_LAST];
            end else begin
                idx_r <= idx_r - 5'h01;
                sdo_r <= word_r[idx_r - 5'h01];
            end
        end
    end

    assign link.sdo = sdo_r;

    // read address: steps during a streamed read, reloads at frame end
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            addr_r <= 7'h00;
        end else if (sync_rise) begin
            addr_r <= sel_write ? rx_r[14:8] : rdsel_r[RS_ADDR_LSB +: 7];
        end else if (sclk_rise && active_r && idx_r == 5'h01 && addr_r < REG_TOP_ADDR) begin
            // step while the last bit is out so the next word is ready before the next edge
            addr_r <= addr_r + 7'h01;
        end
    end

    assign o_rd_addr = addr_r;

    // select register and the two-stage read pending flag
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            rdsel_r <= READ_SELECT_RST;
            rb_pend_r <= 1'b0;
        end else if (sync_rise) begin
            rb_pend_r <= sel_write;
            if (sel_write) begin
                rdsel_r <= rx_r[23:8];
            end
        end
    end

    assign o_read_select = rdsel_r;

    // writes to the rest of the map, and error pulses
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            o_wr_stb <= 1'b0;
            o_wr_addr <= 7'h00;
            o_wr_data <= 16'h0000;
            o_clock_count_error <= 1'b0;
            o_crc_error <= 1'b0;
        end else begin
            o_wr_stb <= sync_rise && accept && !sel_write;
            o_clock_count_error <= sync_rise && !len_ok;
            o_crc_error <= sync_rise && len_ok && !extra_r && (fcnt_r == FRAME_EDGES) && !crc_ok;
            if (sync_rise && accept) begin
                o_wr_addr <= rx_r[30:24];
                o_wr_data <= rx_r[23:8];
            end
        end
    end

endmodule : spi_rb_device

// ### verilog/spi_rb_host.sv
// controller end of the serial link, a classic wishbone slave toward software
// assumes the device end samples on falling and shifts on rising serial clock edges
module spi_rb_host
    import spi_rb_pkg::*;
#(
    parameter int HALF_CYC = SCLK_HALF_CYC
) (
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic [7:0] i_wb_adr,
    input wire logic [31:0] i_wb_dat,
    input wire logic [3:0] i_wb_sel,
    output logic [31:0] o_wb_dat,
    output logic o_wb_ack,
    output logic o_irq,
    spi_rb_if.host link
);

    // the device sees edges three cycles late; shorter halves break the sdo turnaround
    if (HALF_CYC < 4 || HALF_CYC > 255) begin : g_bad_half
        $error("HALF_CYC out of range");
    end

    typedef enum {st_idle, st_lead, st_low, st_high, st_tail, st_hold} host_st_t;

    host_st_t st_r;
    logic [7:0] cnt_r;
    logic [5:0] bits_r;
    logic item_r;
    logic [31:0] tx_r;
    logic [31:0] rx_r;
    logic [31:0] rxd_r;
    logic hold_r;
    logic [1:0] sdo_q;
    logic sclk_r;
    logic sync_n_r;
    logic [IRQ_W-1:0] sts_r;
    logic [IRQ_W-1:0] en_r;
    logic [IRQ_W-1:0] ev;
    logic tick;
    logic acc;
    logic txd_wr;
    logic clr_wr;

    assign acc = i_wb_cyc & i_wb_stb & ~o_wb_ack;
    assign txd_wr = acc & i_wb_we & (i_wb_adr == HOST_TXD) & (st_r == st_idle || st_r == st_hold);
    assign clr_wr = acc & i_wb_we & (i_wb_adr == HOST_IRQ_CLR) & i_wb_sel[0];
    assign tick = (cnt_r == 8'(HALF_CYC - 1));

    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            sdo_q <= 2'h0;
        end else begin
            sdo_q <= {sdo_q[0], link.sdo};
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            o_wb_ack <= 1'b0;
            o_wb_dat <= 32'h0000_0000;
            hold_r <= 1'b0;
            en_r <= '0;
        end else begin
            o_wb_ack <= acc;
            if (acc && !i_wb_we) begin
                case (i_wb_adr)
                    HOST_CTRL: o_wb_dat <= {31'h0, hold_r};
                    HOST_RXD: o_wb_dat <= rxd_r;
                    HOST_IRQ_STS: o_wb_dat <= {{(32 - IRQ_W){1'b0}}, sts_r};
                    HOST_IRQ_EN: o_wb_dat <= {{(32 - IRQ_W){1'b0}}, en_r};
                    HOST_STATE: o_wb_dat <= {30'h0, st_r == st_hold, st_r != st_idle && st_r != st_hold};
                    default: o_wb_dat <= 32'h0000_0000;
                endcase
            end
            if (acc && i_wb_we && i_wb_sel[0]) begin
                if (i_wb_adr == HOST_CTRL) begin
                    hold_r <= i_wb_dat[CTRL_HOLD_BIT];
                end
                if (i_wb_adr == HOST_IRQ_EN) begin
                    en_r <= i_wb_dat[IRQ_W-1:0];
                end
            end
        end
    end

    // frame sequencer; sclk idles high, sdi changes on rising edges, sdo sampled at rising edges
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            st_r <= st_idle;
            cnt_r <= 8'h00;
            bits_r <= 6'h00;
            item_r <= 1'b0;
            tx_r <= 32'h0000_0000;
            rx_r <= 32'h0000_0000;
            sclk_r <= 1'b1;
            sync_n_r <= 1'b1;
        end else begin
            cnt_r <= (st_r == st_idle || st_r == st_hold || tick) ? 8'h00 : cnt_r + 8'h01;
            case (st_r)
                st_idle: begin
                    if (txd_wr) begin
                        tx_r <= {i_wb_dat[23:0], crc8(i_wb_dat[23:0])};
                        bits_r <= 6'(FRAME_BITS);
                        item_r <= 1'b0;
                        sync_n_r <= 1'b0;
                        st_r <= st_lead;
                    end
                end
                st_hold: begin
                    if (txd_wr) begin
                        // continuation item; inbound bits are ignored by the device here
                        tx_r <= 32'h0000_0000;
                        bits_r <= 6'(ITEM_BITS);
                        item_r <= 1'b1;
                        st_r <= st_lead;
                    end else if (!hold_r) begin
                        sync_n_r <= 1'b1;
                        st_r <= st_idle;
                    end
                end
                st_lead, st_high: begin
                    if (tick) begin
                        sclk_r <= 1'b0;
                        st_r <= st_low;
                    end
                end
                st_low: begin
                    if (tick) begin
                        sclk_r <= 1'b1;
                        rx_r <= {rx_r[30:0], sdo_q[1]};
                        tx_r <= {tx_r[30:0], 1'b0};
                        bits_r <= bits_r - 6'h01;
                        st_r <= (bits_r == 6'h01) ? st_tail : st_high;
                    end
                end
                st_tail: begin
                    if (tick) begin
                        sync_n_r <= ~hold_r;
                        st_r <= hold_r ? st_hold : st_idle;
                    end
                end
                default: st_r <= st_idle;
            endcase
        end
    end

    assign link.sclk = sclk_r;
    assign link.sync_n = sync_n_r;
    assign link.sdi = tx_r[31];

    always_comb begin
        ev = '0;
        if (st_r == st_tail && tick) begin
            ev[IRQ_DONE] = 1'b1;
            ev[IRQ_CRC] = !item_r && (rx_r[7:0] != crc8(rx_r[31:8]));
            ev[IRQ_STUCK] = !item_r && !rx_r[31];
        end
    end

    // set wins over a clear in the same cycle
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            sts_r <= '0;
            rxd_r <= 32'h0000_0000;
            o_irq <= 1'b0;
        end else begin
            sts_r <= (sts_r & ~(clr_wr ? i_wb_dat[IRQ_W-1:0] : {IRQ_W{1'b0}})) | ev;
            o_irq <= |(sts_r & en_r);
            if (ev[IRQ_DONE]) begin
                rxd_r <= item_r ? {8'h00, rx_r[23:0]} : rx_r;
            end
        end
    end

endmodule : spi_rb_host

// ### sim/spi_rb_properties.sv
// wire-level properties of the serial readback link between controller and device
// assumes the controller runs its default divider of 4 clocks per serial clock half period
module spi_rb_properties (
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic sclk,
    input wire logic sync_n,
    input wire logic sdi,
    input wire logic sdo
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rstn);

    logic sclk_q;
    logic [7:0] rises;
    logic [3:0] since;

    always_ff @(posedge i_clk) begin
        if (!i_rstn) sclk_q <= 1'b1;
        else sclk_q <= sclk;
    end

    // cleared while deselected, so it reads the edge total at the rise of frame select
    always_ff @(posedge i_clk) begin
        if (!i_rstn || sync_n) rises <= '0;
        else if (sclk && !sclk_q) rises <= rises + 8'd1;
    end

    // saturates so a long quiet spell cannot wrap back into range
    always_ff @(posedge i_clk) begin
        if (!i_rstn || sync_n || (sclk && !sclk_q)) since <= '0;
        else if (since != 4'hf) since <= since + 4'd1;
    end

    sequence s_lead_in;
        sclk [*4] ##1 !sclk;
    endsequence
    sequence s_low_half;
        !sclk [*4] ##1 sclk;
    endsequence

    property p_lead_in;
        $fell(sync_n) |-> s_lead_in;
    endproperty
    property p_msb_one;
        $fell(sync_n) |-> ##4 sdo [*4];
    endproperty
    property p_low_half;
        $fell(sclk) |-> s_low_half;
    endproperty
    property p_sdi_steady;
        $fell(sclk) |-> $stable(sdi);
    endproperty
    property p_framed;
        !sclk |-> !sync_n;
    endproperty
    property p_gap;
        $rose(sync_n) |=> sync_n [*2];
    endproperty
    property p_edge_total;
        $rose(sync_n) |-> (rises == 8'd32) || (rises > 8'd32 && (rises - 8'd32) % 8'd24 == 8'd0);
    endproperty
    property p_sdo_on_rise;
        ($changed(sdo) && !sync_n) |-> since <= 4'd7;
    endproperty

    a_lead_in: assert property (p_lead_in) else $error("serial clock left idle too early");
    a_msb_one: assert property (p_msb_one) else $error("leading output bit not high");
    a_low_half: assert property (p_low_half) else $error("serial clock low phase wrong");
    a_sdi_steady: assert property (p_sdi_steady) else $error("inbound data moved at sampling");
    a_framed: assert property (p_framed) else $error("serial clock low outside a frame");
    a_gap: assert property (p_gap) else $error("frame select high too briefly");
    a_edge_total: assert property (p_edge_total) else $error("frame edge total not 32 plus 24n");
    a_sdo_on_rise: assert property (p_sdo_on_rise) else $error("outbound bit moved away from a rise");
endmodule : spi_rb_properties

// ### sim/test_spi_readback_streaming.sv
// self-checking bench: controller and device joined over the link, a second device driven raw
// assumes the default serial divider and register contents served by the bench
module test_spi_readback_streaming import spi_rb_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;

    logic i_clk = 1'b0;
    logic i_rstn = 1'b0;
    logic wb_cyc = 1'b0;
    logic wb_stb = 1'b0;
    logic wb_we = 1'b0;
    logic [7:0] wb_adr = '0;
    logic [31:0] wb_dat = '0;
    logic [31:0] wb_q, rd_q;
    logic wb_ack, irq, alert = 1'b0, rdy = 1'b0;
    logic [3:0] comp = '0;
    logic [6:0] rd_addr, rd_addr2, wr_addr;
    logic [15:0] wr_data, rsel;
    logic wr_stb, stream, cce, wr_stb2, cce2, crce2;
    int bad_count = 0, n_checks = 0, cycles = 0, wr_cnt = 0, cce_cnt = 0, wr2_cnt = 0, cce2_cnt = 0, crce2_cnt = 0;

    // bench register file: distinct per address, never zero
    function automatic logic [15:0] rv(input logic [6:0] a);
        return {a, 2'b01, ~a};
    endfunction : rv
    function automatic logic [7:0] crc(input logic [23:0] d);
        logic [7:0] c;
        c = 8'h00;
        for (int i = 23; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h07 : 8'h00);
        return c;
    endfunction : crc
    function automatic logic [31:0] word(input logic [6:0] a, input logic info);
        logic [7:0] h;
        h = info ? {2'b10, alert, rdy, comp} : {1'b1, a};
        return {h, rv(a), crc({h, rv(a)})};
    endfunction : word

    spi_rb_if link ();
    spi_rb_if link2 ();
    spi_rb_host #(.HALF_CYC(4)) spi_rb_host_i (.i_clk(i_clk), .i_rstn(i_rstn), .i_wb_cyc(wb_cyc),
        .i_wb_stb(wb_stb), .i_wb_we(wb_we), .i_wb_adr(wb_adr), .i_wb_dat(wb_dat), .i_wb_sel(4'hf),
        .o_wb_dat(wb_q), .o_wb_ack(wb_ack), .o_irq(irq), .link(link.host));
    spi_rb_device spi_rb_device_i (.i_clk(i_clk), .i_rstn(i_rstn), .link(link.dev), .o_rd_addr(rd_addr),
        .i_rd_data(rv(rd_addr)), .i_alert(alert), .i_adc_rdy(rdy), .i_din_comp(comp), .o_wr_stb(wr_stb),
        .o_wr_addr(wr_addr), .o_wr_data(wr_data), .o_read_select(rsel), .o_streaming(stream),
        .o_clock_count_error(cce), .o_crc_error());
    spi_rb_device spi_rb_device_i2 (.i_clk(i_clk), .i_rstn(i_rstn), .link(link2.dev), .o_rd_addr(rd_addr2),
        .i_rd_data(rv(rd_addr2)), .i_alert(alert), .i_adc_rdy(rdy), .i_din_comp(comp), .o_wr_stb(wr_stb2),
        .o_wr_addr(), .o_wr_data(), .o_read_select(), .o_streaming(), .o_clock_count_error(cce2),
        .o_crc_error(crce2));
    spi_rb_properties spi_rb_properties_i (.i_clk(i_clk), .i_rstn(i_rstn), .sclk(link.sclk),
        .sync_n(link.sync_n), .sdi(link.sdi), .sdo(link.sdo));

    initial begin
        forever #5 i_clk = ~i_clk;
    end

    always @(posedge i_clk) begin
        cycles <= cycles + 1;
        wr_cnt <= wr_cnt + int'(wr_stb);
        cce_cnt <= cce_cnt + int'(cce);
        wr2_cnt <= wr2_cnt + int'(wr_stb2);
        cce2_cnt <= cce2_cnt + int'(cce2);
        crce2_cnt <= crce2_cnt + int'(crce2);
        if (cycles == 40000) begin
            bad_count++;
            complete_run();
        end
    end

    task automatic complete_run();
        if (bad_count == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : complete_run

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clk);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= w;
        wb_adr <= a;
        wb_dat <= d;
        do @(posedge i_clk); while (wb_ack !== 1'b1);
        rd_q = wb_q;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
    endtask : wb

    task automatic rdchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        wb(1'b0, a, 32'h0);
        chk(rd_q & m, e);
    endtask : rdchk

    // one controller frame; returns once the busy flag clears
    // device strobes land a few cycles after select rises, so let them settle first
    task automatic frame(input logic [23:0] b);
        wb(1'b1, HOST_TXD, {8'h00, b});
        do wb(1'b0, HOST_STATE, 32'h0); while (rd_q[0] !== 1'b0);
        repeat (6) @(posedge i_clk);
    endtask : frame

    // raw frame on the second link; the edge total and crc are ours to break
    task automatic raw(input int n, input logic [31:0] w);
        @(posedge i_clk);
        link2.sync_n <= 1'b0;
        link2.sdi <= w[31];
        for (int i = 1; i <= n; i++) begin
            repeat (4) @(posedge i_clk);
            link2.sclk <= 1'b0;
            repeat (4) @(posedge i_clk);
            link2.sclk <= 1'b1;
            link2.sdi <= w[(63 - i) % 32];
        end
        repeat (4) @(posedge i_clk);
        link2.sync_n <= 1'b1;
        link2.sdi <= ~link2.sdi;
        repeat (8) @(posedge i_clk);
    endtask : raw

    task automatic t_irq();
        rdchk(HOST_IRQ_EN, 32'hffffffff, 32'h0);
        rdchk(8'hfc, 32'hffffffff, 32'h0);
        wb(1'b1, HOST_IRQ_CLR, 32'h7);
        wb(1'b1, HOST_IRQ_EN, 32'h1);
        frame(24'h000000);
        chk(32'(irq), 32'h1);
        wb(1'b1, HOST_IRQ_CLR, 32'h1);
        repeat (2) @(posedge i_clk);
        chk(32'(irq), 32'h0);
        wb(1'b1, HOST_IRQ_EN, 32'h0);
        frame(24'h000000);
        chk(32'(irq), 32'h0);
        rdchk(HOST_IRQ_STS, 32'h7, 32'h1);
    endtask : t_irq

    task automatic t_write();
        int n;
        n = wr_cnt;
        frame(24'h451234);
        chk(wr_cnt - n, 1);
        chk(32'(wr_addr), 32'h45);
        chk(32'(wr_data), 32'h1234);
    endtask : t_write

    task automatic t_read();
        frame(24'h410005);
        chk(32'(rsel), 32'h5);
        frame(24'h000000);
        rdchk(HOST_RXD, 32'hffffffff, word(7'h05, 1'b0));
        alert <= 1'b1;
        comp <= 4'ha;
        frame(24'h410083);
        frame(24'h000000);
        rdchk(HOST_RXD, 32'hffffffff, word(7'h03, 1'b1));
        alert <= 1'b0;
        comp <= 4'h0;
    endtask : t_read

    task automatic t_auto();
        frame(24'h410105);
        for (int k = 0; k < 3; k++) begin
            frame((k == 2) ? 24'h45beef : 24'h000000);
            rdchk(HOST_RXD, 32'hffffffff, word(7'h05, 1'b0));
        end
        chk(32'(wr_data), 32'hbeef);
        frame(24'h410000);
    endtask : t_auto

    task automatic t_stream();
        int n;
        int e;
        logic [31:0] w;
        frame(24'h410044);
        wb(1'b1, HOST_CTRL, 32'h1);
        n = wr_cnt;
        e = cce_cnt;
        frame(24'h000000);
        rdchk(HOST_RXD, 32'hffffffff, word(7'h44, 1'b0));
        for (int k = 0; k < 3; k++) begin
            w = word((k == 0) ? 7'h45 : 7'h46, 1'b0);
            frame(24'h455555);
            rdchk(HOST_RXD, 32'h00ffffff, {8'h00, w[23:0]});
            chk(32'(stream), 32'h1);
        end
        wb(1'b1, HOST_CTRL, 32'h0);
        do @(posedge i_clk); while (link.sync_n !== 1'b1);
        repeat (8) @(posedge i_clk);
        chk(32'(stream), 32'h0);
        chk(wr_cnt - n, 0);
        chk(cce_cnt - e, 0);
    endtask : t_stream

    task automatic t_faults();
        int n;
        int c;
        int r;
        logic [31:0] w;
        w = {24'h4500ff, crc(24'h4500ff)};
        n = wr2_cnt;
        c = cce2_cnt;
        r = crce2_cnt;
        raw(31, w);
        raw(32, w ^ 32'h1);
        chk(wr2_cnt - n, 0);
        chk(cce2_cnt - c, 1);
        chk(crce2_cnt - r, 1);
        raw(32, w);
        chk(wr2_cnt - n, 1);
        // streamed reads: a cut item is an error, a whole one is not
        w = {24'h410045, crc(24'h410045)};
        raw(32, w);
        raw(40, w);
        chk(cce2_cnt - c, 2);
        raw(32, w);
        raw(56, w);
        chk(cce2_cnt - c, 2);
        chk(wr2_cnt - n, 1);
    endtask : t_faults

    initial begin
        link2.sclk = 1'b1;
        link2.sync_n = 1'b1;
        link2.sdi = 1'b0;
        repeat (10) @(posedge i_clk);
        i_rstn <= 1'b1;
        t_irq();
        t_write();
        t_read();
        t_auto();
        t_stream();
        t_faults();
        complete_run();
    end
endmodule : test_spi_readback_streaming
